// ==== hw/bdma_pkg.sv ====
// package: constants, op encoding and bank helpers for the banked data memory addressing block
package bdma_pkg;
  // address and data geometry
  localparam int ADDR_W = 12;
  localparam int DATA_W = 8;
  localparam int BANK_W = 4;
  localparam int OFFS_W = 8;
  localparam int NUM_BANKS = 16;
  localparam int BANK_BYTES = 256;
  localparam int MEM_BYTES = NUM_BANKS * BANK_BYTES;

  // fast-access window: low offsets land in the first bank, high offsets in the last bank
  localparam logic [7:0] FAST_SPLIT = 8'h60;
  localparam logic [3:0] FAST_LOW_BANK = 4'h0;
  localparam logic [3:0] FAST_HIGH_BANK = 4'hf;

  // special function area at the top of the last bank
  localparam logic [11:0] SPECIAL_LO = 12'hf38;
  localparam logic [11:0] SPECIAL_HI = 12'hfff;

  // default set of implemented banks, one bit per bank
  localparam logic [15:0] IMPL_BANKS_DEF = 16'h800f;

  // software register port offsets
  localparam logic [1:0] REG_BANK_PTR = 2'h0;
  localparam logic [1:0] REG_LAST_LO = 2'h1;
  localparam logic [1:0] REG_LAST_HI = 2'h2;

  // field positions and reset values
  localparam int LAST_HI_IMPL_BIT = 7;
  localparam int LAST_HI_SPECIAL_BIT = 6;
  localparam logic [3:0] BANK_PTR_RST = 4'h0;
  localparam logic [7:0] BYTE_ZERO = 8'h00;
  localparam logic [11:0] ADDR_ZERO = 12'h000;

  // operations presented by the core datapath
  typedef enum logic [1:0] {
    OP_NONE,
    OP_BANKED,
    OP_FULL_MOVE,
    OP_LOAD_BANK
  } bdma_op_t;

  // true when the bank holding the address is implemented
  function automatic logic bank_impl(input logic [11:0] addr, input logic [15:0] mask);
    bank_impl = mask[addr[11:8]];
  endfunction

  // true when the address lies in the special function area
  function automatic logic in_special(input logic [11:0] addr);
    in_special = (addr >= SPECIAL_LO) && (addr <= SPECIAL_HI);
  endfunction
endpackage

// ==== hw/bdma_decode.sv ====
// address decoder: turns bank pointer, access select and offset into a 12-bit data address
`timescale 1ns/100ps
module bdma_decode #(
  parameter logic [15:0] IMPL_BANKS = bdma_pkg::IMPL_BANKS_DEF
) (
  input wire logic [3:0] bank_ptr, // current bank pointer
  input wire logic access_sel, // 1: use bank pointer, 0: fast-access window
  input wire logic [7:0] offset, // low-order address from the instruction
  input wire logic ext_cfg, // extended set config bit
  input wire logic [11:0] ext_fast_addr, // alternative fast-access address, supplied outside
  output logic [11:0] addr, // resolved address
  output logic impl, // address falls in an implemented bank
  output logic special // address falls in the special function area
);
  //////////////////////////////////////////////////////////////////////////////
  // address formation
  always_comb begin
    if (access_sel) begin
      addr = {bank_ptr, offset};
    end else if (ext_cfg) begin
      // extended mapping is not built here; the core hands in the result
      addr = ext_fast_addr;
    end else if (offset < bdma_pkg::FAST_SPLIT) begin
      addr = {bdma_pkg::FAST_LOW_BANK, offset};
    end else begin
      addr = {bdma_pkg::FAST_HIGH_BANK, offset};
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // region flags
  assign impl = bdma_pkg::bank_impl(addr, IMPL_BANKS);
  assign special = bdma_pkg::in_special(addr);
endmodule

// ==== hw/bdma_core.sv ====
// banked data memory: address generation, bank pointer, storage and unimplemented-bank handling
//
// Summary of operation
// - data memory is static RAM addressed by a 12-bit byte address, 4096 bytes
// - sixteen banks of 256 bytes; top four bits pick bank, low eight the byte
// - reading an unimplemented location returns all zeros
// - bank-relative address is bank pointer on top, instruction offset below
// - bank pointer keeps only bits 3..0; upper bits read zero, ignore writes
// - load-bank-literal operation writes an immediate into the bank pointer
// - writes to unimplemented banks are dropped; reads from them give zero
// - status flags update as if the access succeeded, even in absent banks
// - full-address move uses whole 12-bit source and target, ignores bank pointer
// - all other data accesses give an 8-bit offset, resolved by pointer or window
// - fast window: 00h-5Fh to bank 0 start, 60h-FFh to bank 15 top
// - access select one: address from bank pointer plus offset
// - access select zero: fast window used, bank pointer ignored
// - fast-window access completes in one cycle with no pointer update first
// - with the extended set bit one, the window mapping comes from outside
// - special function area spans F38h to FFFh in bank 15
// - general storage is never cleared by any reset
`timescale 1ns/100ps
module bdma_core #(
  parameter logic [15:0] IMPL_BANKS = bdma_pkg::IMPL_BANKS_DEF
) (
  input wire logic clk, // core clock, 100 MHz
  input wire logic srst, // synchronous reset, active high
  input wire bdma_pkg::bdma_op_t op, // operation from the datapath, one cycle each
  input wire logic op_wr, // banked op: 1 write, 0 read
  input wire logic access_sel, // banked op: access-select bit
  input wire logic [7:0] offset, // banked op: low-order address
  input wire logic [7:0] wr_data, // banked op: byte to write
  input wire logic [7:0] literal, // load-bank op: immediate
  input wire logic [11:0] move_src, // full move: source address
  input wire logic [11:0] move_dst, // full move: destination address
  input wire logic ext_cfg, // extended-set config bit
  input wire logic [11:0] ext_fast_addr, // alternative window address for ext_cfg
  input wire logic [1:0] reg_addr, // register port address
  input wire logic [7:0] reg_wdata, // register port write data
  input wire logic reg_wr, // register port write strobe
  input wire logic reg_rd, // register port read strobe
  output logic [7:0] reg_rdata, // register read data, cycle after strobe
  output logic [7:0] rd_data, // byte read or moved, cycle after op
  output logic rd_valid, // pulse: a data access completed
  output logic [11:0] addr_out, // resolved address of the completed access
  output logic impl_out, // completed access hit an implemented bank
  output logic special_out, // completed access hit the special function area
  output logic flags_upd, // pulse: status flags may update
  output logic [3:0] bank_ptr_out // current bank pointer
);
  //////////////////////////////////////////////////////////////////////////////
  // state
  typedef struct packed {
    logic [3:0] bank_ptr;
    logic [7:0] rd_data;
    logic rd_valid;
    logic [11:0] addr;
    logic impl;
    logic special;
    logic flags_upd;
    logic [7:0] reg_rdata;
    logic [11:0] last_addr;
    logic last_impl;
    logic last_special;
  } bdma_st_t;

  bdma_st_t st_ff;
  bdma_st_t nxt_st;

  // storage is a plain array, outside the reset state
  logic [7:0] mem [bdma_pkg::MEM_BYTES];

  logic [11:0] dec_addr;
  logic dec_impl;
  logic dec_special;
  logic src_impl;
  logic dst_impl;
  logic [7:0] src_byte;
  logic [7:0] bank_byte;
  logic mem_we;
  logic [11:0] mem_waddr;
  logic [7:0] mem_wdata;
  logic banked;
  logic moving;

  assign banked = (op == bdma_pkg::OP_BANKED);
  assign moving = (op == bdma_pkg::OP_FULL_MOVE);

  //////////////////////////////////////////////////////////////////////////////
  // address decoding for offset-only accesses
  bdma_decode #(
    .IMPL_BANKS(IMPL_BANKS)
  ) u_decode (
    .bank_ptr(st_ff.bank_ptr),
    .access_sel(access_sel),
    .offset(offset),
    .ext_cfg(ext_cfg),
    .ext_fast_addr(ext_fast_addr),
    .addr(dec_addr),
    .impl(dec_impl),
    .special(dec_special)
  );

  // full move addresses bypass the bank pointer completely
  assign src_impl = bdma_pkg::bank_impl(move_src, IMPL_BANKS);
  assign dst_impl = bdma_pkg::bank_impl(move_dst, IMPL_BANKS);

  //////////////////////////////////////////////////////////////////////////////
  // array reads; absent banks yield zero instead of stale array contents
  always_comb begin
    src_byte = bdma_pkg::BYTE_ZERO;
    bank_byte = bdma_pkg::BYTE_ZERO;
    if (src_impl) begin
      src_byte = mem[move_src];
    end
    if (dec_impl) begin
      bank_byte = mem[dec_addr];
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // array write port; absent destinations are dropped
  always_comb begin
    mem_we = 1'b0;
    mem_waddr = bdma_pkg::ADDR_ZERO;
    mem_wdata = bdma_pkg::BYTE_ZERO;
    if (moving) begin
      mem_we = dst_impl;
      mem_waddr = move_dst;
      mem_wdata = src_byte;
    end else if (banked && op_wr) begin
      mem_we = dec_impl;
      mem_waddr = dec_addr;
      mem_wdata = wr_data;
    end
  end

  // no reset here: contents survive every reset and start undefined
  always_ff @(posedge clk) begin
    if (mem_we) begin
      mem[mem_waddr] <= mem_wdata;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // next state
  always_comb begin
    nxt_st = st_ff;
    nxt_st.rd_valid = 1'b0;
    nxt_st.flags_upd = 1'b0;
    nxt_st.reg_rdata = bdma_pkg::BYTE_ZERO;
    // software write to the bank pointer; upper bits are simply not stored
    if (reg_wr && (reg_addr == bdma_pkg::REG_BANK_PTR)) begin
      nxt_st.bank_ptr = reg_wdata[3:0];
    end
    // datapath literal load wins over a software write in the same cycle
    if (op == bdma_pkg::OP_LOAD_BANK) begin
      nxt_st.bank_ptr = literal[3:0];
    end
    // one access per cycle, finished the cycle after it is presented
    if (banked) begin
      nxt_st.rd_valid = 1'b1;
      nxt_st.addr = dec_addr;
      nxt_st.impl = dec_impl;
      nxt_st.special = dec_special;
      nxt_st.rd_data = op_wr ? bdma_pkg::BYTE_ZERO : bank_byte;
      // flags follow the operation, not whether the bank exists
      nxt_st.flags_upd = 1'b1;
    end else if (moving) begin
      nxt_st.rd_valid = 1'b1;
      nxt_st.addr = move_dst;
      nxt_st.impl = dst_impl;
      nxt_st.special = bdma_pkg::in_special(move_dst);
      nxt_st.rd_data = src_byte;
      nxt_st.flags_upd = 1'b1;
    end
    if (banked || moving) begin
      nxt_st.last_addr = nxt_st.addr;
      nxt_st.last_impl = nxt_st.impl;
      nxt_st.last_special = nxt_st.special;
    end
    // register port reads; unmapped offsets read zero
    if (reg_rd) begin
      case (reg_addr)
        bdma_pkg::REG_BANK_PTR: begin
          nxt_st.reg_rdata = {4'h0, st_ff.bank_ptr};
        end
        bdma_pkg::REG_LAST_LO: begin
          nxt_st.reg_rdata = st_ff.last_addr[7:0];
        end
        bdma_pkg::REG_LAST_HI: begin
          nxt_st.reg_rdata = {st_ff.last_impl, st_ff.last_special, 2'h0, st_ff.last_addr[11:8]};
        end
        default: begin
          nxt_st.reg_rdata = bdma_pkg::BYTE_ZERO;
        end
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // state register
  always_ff @(posedge clk) begin
    if (srst) begin
      st_ff <= '0;
      st_ff.bank_ptr <= bdma_pkg::BANK_PTR_RST;
    end else begin
      st_ff <= nxt_st;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // outputs straight from the state register
  assign reg_rdata = st_ff.reg_rdata;
  assign rd_data = st_ff.rd_data;
  assign rd_valid = st_ff.rd_valid;
  assign addr_out = st_ff.addr;
  assign impl_out = st_ff.impl;
  assign special_out = st_ff.special;
  assign flags_upd = st_ff.flags_upd;
  assign bank_ptr_out = st_ff.bank_ptr;

  //////////////////////////////////////////////////////////////////////////////
  // checks
  bank_rel_addr_a: assert property (
    @(posedge clk) disable iff (srst)
    (banked && access_sel) |=> (addr_out == {$past(st_ff.bank_ptr), $past(offset)}))
    else $error("bank-relative address not pointer plus offset");

  fast_low_a: assert property (
    @(posedge clk) disable iff (srst)
    (banked && !access_sel && !ext_cfg && (offset < 8'h60)) |=> (addr_out[11:8] == 4'h0))
    else $error("low window offset not mapped to bank 0");

  fast_high_a: assert property (
    @(posedge clk) disable iff (srst)
    (banked && !access_sel && !ext_cfg && (offset >= 8'h60))
      |=> (addr_out == {4'hf, $past(offset)}))
    else $error("high window offset not mapped to bank 15");

  ext_window_a: assert property (
    @(posedge clk) disable iff (srst)
    (banked && !access_sel && ext_cfg) |=> (addr_out == $past(ext_fast_addr)))
    else $error("extended window address not taken from outside");

  // a move into an absent bank still shows the byte it carried, so only absent sources count here
  absent_read_a: assert property (
    @(posedge clk) disable iff (srst)
    ((banked && !dec_impl) || (moving && !src_impl))
      |=> (rd_data == 8'h00))
    else $error("absent bank read returned nonzero");

  absent_write_a: assert property (
    @(posedge clk) disable iff (srst)
    mem_we |-> IMPL_BANKS[mem_waddr[11:8]])
    else $error("write reached an absent bank");

  flags_always_a: assert property (
    @(posedge clk) disable iff (srst)
    (banked || moving) |=> (flags_upd && rd_valid))
    else $error("flag update missing after data access");

  one_cycle_a: assert property (
    @(posedge clk) disable iff (srst)
    (banked && !access_sel) |=> (rd_valid && (bank_ptr_out == $past(st_ff.bank_ptr)
      || $past(op) == bdma_pkg::OP_LOAD_BANK || $past(reg_wr))))
    else $error("window access took more than one cycle");

  upper_zero_a: assert property (
    @(posedge clk) disable iff (srst)
    (reg_rd && reg_addr == 2'h0) |=> (reg_rdata[7:4] == 4'h0 && reg_rdata[3:0] == $past(st_ff.bank_ptr)))
    else $error("bank pointer read wrong");

  load_literal_a: assert property (
    @(posedge clk) disable iff (srst)
    (op == bdma_pkg::OP_LOAD_BANK) |=> (bank_ptr_out == $past(literal[3:0])))
    else $error("literal not loaded into bank pointer");

  move_addr_a: assert property (
    @(posedge clk) disable iff (srst)
    moving |=> (addr_out == $past(move_dst) && impl_out == IMPL_BANKS[addr_out[11:8]]))
    else $error("full move address or presence flag wrong");

  impl_flag_a: assert property (
    @(posedge clk) disable iff (srst)
    rd_valid |-> (impl_out == IMPL_BANKS[addr_out[11:8]]))
    else $error("presence flag disagrees with bank set");

  special_flag_a: assert property (
    @(posedge clk) disable iff (srst)
    rd_valid |-> (special_out == (addr_out >= 12'hf38)))
    else $error("special area flag wrong");

  //////////////////////////////////////////////////////////////////////////////
  // address select, window special flag, bank pointer, storage, completion pulse, reset and register port checks
  ext_sel_a: assert property (
    @(posedge clk) disable iff (srst)
    (banked && access_sel && ext_cfg)
      |=> (addr_out == {$past(st_ff.bank_ptr), $past(offset)}))
    else $error("access select one did not use the bank pointer");

  ptr_write_a: assert property (
    @(posedge clk) disable iff (srst)
    (reg_wr && reg_addr == bdma_pkg::REG_BANK_PTR && op != bdma_pkg::OP_LOAD_BANK)
      |=> (bank_ptr_out == $past(reg_wdata[3:0])))
    else $error("software write did not set bank pointer");

  ptr_steady_a: assert property (
    @(posedge clk) disable iff (srst)
    (op != bdma_pkg::OP_LOAD_BANK && !(reg_wr && reg_addr == bdma_pkg::REG_BANK_PTR))
      |=> $stable(bank_ptr_out))
    else $error("bank pointer moved without a load");

  window_special_a: assert property (
    @(posedge clk) disable iff (srst)
    (banked && !access_sel && !ext_cfg)
      |=> (special_out == ($past(offset) >= bdma_pkg::FAST_SPLIT)))
    else $error("window half and special area disagree");

  write_lands_a: assert property (
    @(posedge clk) disable iff (srst)
    (banked && op_wr && dec_impl) |=> (mem[addr_out] == $past(wr_data)))
    else $error("banked write did not land in storage");

  write_quiet_a: assert property (
    @(posedge clk) disable iff (srst)
    (banked && op_wr) |=> (rd_data == 8'h00))
    else $error("banked write returned a data byte");

  access_quiet_a: assert property (
    @(posedge clk) disable iff (srst)
    !(banked || moving) |=> (!rd_valid && !flags_upd))
    else $error("completion pulse without a data access");

  reset_clear_a: assert property (
    @(posedge clk)
    srst |=> (bank_ptr_out == 4'h0 && !rd_valid && !flags_upd && reg_rdata == 8'h00))
    else $error("reset did not clear pointer and pulses");

  last_hi_a: assert property (
    @(posedge clk) disable iff (srst)
    (reg_rd && reg_addr == bdma_pkg::REG_LAST_HI)
      |=> (reg_rdata == {$past(impl_out), $past(special_out), 2'h0, $past(addr_out[11:8])}))
    else $error("last address high register wrong");

  last_lo_a: assert property (
    @(posedge clk) disable iff (srst)
    (reg_rd && reg_addr == bdma_pkg::REG_LAST_LO) |=> (reg_rdata == $past(addr_out[7:0])))
    else $error("last address low register wrong");
endmodule

// ==== bench/bdma_datapath_model.sv ====
// core datapath model: issues one data operation per call toward the banked memory block
`timescale 1ns/100ps
module bdma_datapath_model (
  input wire logic clk, // core clock
  output bdma_pkg::bdma_op_t op, // operation code
  output logic op_wr, // 1 write, 0 read
  output logic access_sel, // 1 bank pointer, 0 fast window
  output logic [7:0] offset, // low-order address
  output logic [7:0] wr_data, // write byte
  output logic [7:0] literal, // pointer immediate
  output logic [11:0] move_src, // move source
  output logic [11:0] move_dst, // move target
  output logic ext_cfg, // extended set bit
  output logic [11:0] ext_fast_addr // outside window address
);
  ////////////////////////////////////////////////////////////////////////////
  // idle values at time zero
  initial begin
    op = bdma_pkg::OP_NONE;
    {op_wr, access_sel, offset, wr_data, literal} = '0;
    {move_src, move_dst, ext_cfg, ext_fast_addr} = '0;
  end

  ////////////////////////////////////////////////////////////////////////////
  // each op stands for exactly one edge; returns at the taking edge
  task automatic issue(input bdma_pkg::bdma_op_t o);
    op <= o;
    @(posedge clk);
    op <= bdma_pkg::OP_NONE;
  endtask

  // only the low byte travels with a banked op
  task automatic banked(input logic w, input logic s, input logic [7:0] off, input logic [7:0] d);
    @(posedge clk);
    op_wr <= w;
    access_sel <= s;
    offset <= off;
    wr_data <= d;
    issue(bdma_pkg::OP_BANKED);
  endtask

  // full addresses on both sides, no pointer involved
  task automatic move(input logic [11:0] s, input logic [11:0] d);
    @(posedge clk);
    move_src <= s;
    move_dst <= d;
    issue(bdma_pkg::OP_FULL_MOVE);
  endtask

  task automatic load(input logic [7:0] l);
    @(posedge clk);
    literal <= l;
    issue(bdma_pkg::OP_LOAD_BANK);
  endtask

  // extended mapping stays set until changed again
  task automatic set_ext(input logic c, input logic [11:0] a);
    @(posedge clk);
    ext_cfg <= c;
    ext_fast_addr <= a;
  endtask
endmodule

// ==== bench/tb.sv ====
// self-checking bench for the banked data memory addressing block
`timescale 1ns/100ps
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin fail_count++; \
  $display("wrong value at %0t: got %h expected %h", $time, a, b); end end
module tb;
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic [1:0] reg_addr = 2'h0;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  bdma_pkg::bdma_op_t op;
  logic op_wr, access_sel, ext_cfg, rd_valid, impl_out, special_out, flags_upd;
  logic [7:0] offset, wr_data, literal, reg_rdata, rd_data;
  logic [11:0] move_src, move_dst, ext_fast_addr, addr_out;
  logic [3:0] bank_ptr_out;
  int fail_count = 0;
  int checks = 0;

  always #5 clk = ~clk;

  bdma_datapath_model u_dp (.clk(clk), .op(op), .op_wr(op_wr), .access_sel(access_sel), .offset(offset),
    .wr_data(wr_data), .literal(literal), .move_src(move_src), .move_dst(move_dst), .ext_cfg(ext_cfg),
    .ext_fast_addr(ext_fast_addr));

  bdma_core #(.IMPL_BANKS(16'h800f)) u_dut (.clk(clk), .srst(srst), .op(op), .op_wr(op_wr),
    .access_sel(access_sel), .offset(offset), .wr_data(wr_data), .literal(literal), .move_src(move_src),
    .move_dst(move_dst), .ext_cfg(ext_cfg), .ext_fast_addr(ext_fast_addr), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .rd_data(rd_data),
    .rd_valid(rd_valid), .addr_out(addr_out), .impl_out(impl_out), .special_out(special_out),
    .flags_upd(flags_upd), .bank_ptr_out(bank_ptr_out));

  ////////////////////////////////////////////////////////////////////////////
  // register port: one-cycle strobes, read data only in the following cycle
  task automatic rwr(input logic [1:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask

  task automatic rrd(input logic [1:0] a, input logic [7:0] e);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 `CHK(reg_rdata, e)
  endtask

  // banked access, then the completion pulses, address and byte are compared
  task automatic acc(input logic w, input logic s, input logic [7:0] off, input logic [7:0] d,
                     input logic [11:0] ea, input logic ei, input logic [7:0] er);
    u_dp.banked(w, s, off, d);
    #1 `CHK({rd_valid, flags_upd, impl_out}, {2'b11, ei})
    `CHK(addr_out, ea)
    `CHK(rd_data, er)
  endtask

  task automatic test_done;
    $display("comparisons %0d, mismatches %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // hang guard: far beyond the length of the sequence below
  initial begin
    repeat (3000) @(posedge clk);
    fail_count++;
    test_done;
  end

  ////////////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    repeat (12) @(posedge clk);
    srst <= 1'b0;
    rrd(2'h0, 8'h00);
    rwr(2'h0, 8'hf2);
    rrd(2'h0, 8'h02);
    u_dp.load(8'ha3);
    #1 `CHK(bank_ptr_out, 4'h3)
    acc(1'b1, 1'b1, 8'h45, 8'h5a, 12'h345, 1'b1, 8'h00);
    acc(1'b0, 1'b1, 8'h45, 8'h00, 12'h345, 1'b1, 8'h5a);
    // fast window ignores the pointer at offset 5Fh, the top of the low half of the split
    acc(1'b1, 1'b0, 8'h5f, 8'h11, 12'h05f, 1'b1, 8'h00);
    acc(1'b0, 1'b0, 8'h5f, 8'h00, 12'h05f, 1'b1, 8'h11);
    // storage starts unknown, so every byte read back was written first
    acc(1'b1, 1'b0, 8'h60, 8'h3c, 12'hf60, 1'b1, 8'h00);
    `CHK(special_out, 1'b1)
    acc(1'b1, 1'b1, 8'h37, 8'h66, 12'h337, 1'b1, 8'h00);
    `CHK(special_out, 1'b0)
    acc(1'b0, 1'b1, 8'h37, 8'h00, 12'h337, 1'b1, 8'h66);
    acc(1'b0, 1'b0, 8'h60, 8'h00, 12'hf60, 1'b1, 8'h3c);
    // bank 5 is absent: write dropped, read zero, flags still pulse
    u_dp.load(8'h05);
    acc(1'b1, 1'b1, 8'h20, 8'h77, 12'h520, 1'b0, 8'h00);
    acc(1'b0, 1'b1, 8'h20, 8'h00, 12'h520, 1'b0, 8'h00);
    rrd(2'h2, 8'h05);
    rrd(2'h1, 8'h20);
    rrd(2'h3, 8'h00);
    // moves ignore the pointer, which still selects the absent bank
    u_dp.move(12'h345, 12'h0ff);
    #1 `CHK({rd_valid, impl_out, addr_out, rd_data}, {2'b11, 12'h0ff, 8'h5a})
    u_dp.move(12'h520, 12'h0fe);
    #1 `CHK({flags_upd, addr_out, rd_data}, {1'b1, 12'h0fe, 8'h00})
    u_dp.load(8'h00);
    acc(1'b0, 1'b1, 8'hff, 8'h00, 12'h0ff, 1'b1, 8'h5a);
    // extended mapping takes the window address from outside
    u_dp.set_ext(1'b1, 12'h200);
    acc(1'b1, 1'b0, 8'h10, 8'h44, 12'h200, 1'b1, 8'h00);
    acc(1'b0, 1'b0, 8'h10, 8'h00, 12'h200, 1'b1, 8'h44);
    acc(1'b0, 1'b1, 8'h5f, 8'h00, 12'h05f, 1'b1, 8'h11);
    u_dp.set_ext(1'b0, 12'h000);
    // a nonzero pointer first, so the reset really has something to clear
    u_dp.load(8'h0c);
    #1 `CHK(bank_ptr_out, 4'hc)
    // a reset in mid-run clears the pointer but keeps the stored bytes
    @(posedge clk);
    srst <= 1'b1;
    repeat (2) @(posedge clk);
    srst <= 1'b0;
    #1 `CHK(bank_ptr_out, 4'h0)
    u_dp.load(8'h03);
    acc(1'b0, 1'b1, 8'h45, 8'h00, 12'h345, 1'b1, 8'h5a);
    test_done;
  end
endmodule
